/* include/sca_cfg.svh */
// constants for the comma-aligning serializer/deserializer port
`ifndef SCA_CFG_SVH
`define SCA_CFG_SVH

// ****************************************************************
// word and line geometry
// ****************************************************************
`define SCA_WORD_W        10
`define SCA_WIN_W         20
`define SCA_OFF_W         4
`define SCA_OFF_CNT       10
`define SCA_CTL_W         2

// ****************************************************************
// comma pattern, receive bits 0..6, bit 0 first in time
// ****************************************************************
`define SCA_COMMA_W       7
`define SCA_COMMA_PAT     7'h7C

// ****************************************************************
// reset and idle values
// ****************************************************************
`define SCA_WORD_ZERO     10'h000
`define SCA_WORD_ONES     10'h3FF
`define SCA_WIN_ZERO      20'h0_0000
`define SCA_OFF_RST       4'h0
`define SCA_CTL_RST       2'h0

// ****************************************************************
// control vector bit positions
// ****************************************************************
`define SCA_CTL_ALIGN     0
`define SCA_CTL_LOOP      1

// ****************************************************************
// timing
// ****************************************************************
`define SCA_CLK_MHZ       125
`define SCA_BITS_PER_TICK 10

`endif

/* include/sca_pkg.sv */
// types for the comma-aligning serializer/deserializer port
`default_nettype none
`include "sca_cfg.svh"

package sca_pkg;

	// differential serial beat, bit 0 is first in time
	typedef struct packed {
		logic [`SCA_WORD_W-1:0] pos;
		logic [`SCA_WORD_W-1:0] neg;
	} sca_line_type;

	// receive side output group
	typedef struct packed {
		logic [`SCA_WORD_W-1:0] word;
		logic                   comma_seen_flag;
	} sca_rx_type;

	// recovered clock phase, one-hot
	typedef enum logic [1:0] {
		SCA_PH_EVEN = 2'b01,
		SCA_PH_ODD  = 2'b10
	} sca_phase_type;

endpackage

`default_nettype wire

/* hdl/sca_comma_align_port.sv */
// comma-aligning 10-bit serializer/deserializer port, device side
// Contract
// - each ref tick rising edge captures all ten transmit bits together
// - transmit word goes out on the line bit zero first, bit nine last
// - ref tick is 125 MHz; line rate is ten bits per tick
// - two complementary recovered clocks run at one twentieth of line rate
// - a new receive word appears at each rising edge of either recovered clock
// - first received line bit lands in receive bit zero, later bits ascend
// - comma align enable high activates alignment and the comma flag; low silences flag
// - flag rises when output word bits zero to six hold the comma pattern
// - flag lasts half a recovered period, with the comma word, odd clock samples it
// - loopback select feeds the transmit stream back into the receive path
// - in loopback positive line output stays high, negative stays low
// - misplaced comma with alignment on shifts the word boundary to bits zero to six
// - misplaced means offset, straddling two words, or on the even clock word
// - alignment off keeps the word boundary fixed whatever data arrives
// - up to three words before the comma may be corrupted during realignment
`timescale 1ns/100ps
`default_nettype none
`include "sca_cfg.svh"

module sca_comma_align_port
	import sca_pkg::*;
(
	input  wire logic                   core_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic [`SCA_WORD_W-1:0] tx_word_i,
	input  wire logic [`SCA_WORD_W-1:0] serial_rx_i,
	input  wire logic                   comma_align_enable_i,
	input  wire logic                   internal_loopback_sel_i,
	output var  sca_line_type           serial_tx_o,
	output var  sca_rx_type             rx_o,
	output logic                        recovered_clk_even_o,
	output logic                        recovered_clk_odd_o
);

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic rst_meta_ff;
	logic rst_sync_ff;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	wire logic rst_n;
	assign rst_n = rst_sync_ff;

	// ****************************************************************
	// control pin synchronisers, three stages, change once two agree
	// ****************************************************************
	logic [`SCA_CTL_W-1:0] ctl_raw;
	logic [`SCA_CTL_W-1:0] ctl_s1_ff;
	logic [`SCA_CTL_W-1:0] ctl_s2_ff;
	logic [`SCA_CTL_W-1:0] ctl_s3_ff;
	logic [`SCA_CTL_W-1:0] ctl_ff;

	assign ctl_raw[`SCA_CTL_ALIGN] = comma_align_enable_i;
	assign ctl_raw[`SCA_CTL_LOOP]  = internal_loopback_sel_i;

	genvar gi;
	generate
		for (gi = 0; gi < `SCA_CTL_W; gi = gi + 1) begin : g_sync
			always_ff @(posedge core_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					ctl_s1_ff[gi] <= 1'b0;
					ctl_s2_ff[gi] <= 1'b0;
					ctl_s3_ff[gi] <= 1'b0;
					ctl_ff[gi]    <= 1'b0;
				end else begin
					ctl_s1_ff[gi] <= ctl_raw[gi];
					ctl_s2_ff[gi] <= ctl_s1_ff[gi];
					ctl_s3_ff[gi] <= ctl_s2_ff[gi];
					if (ctl_s2_ff[gi] == ctl_s3_ff[gi]) begin
						ctl_ff[gi] <= ctl_s3_ff[gi];
					end
				end
			end
		end
	endgenerate

	wire logic align_en;
	wire logic loop_en;
	assign align_en = ctl_ff[`SCA_CTL_ALIGN];
	assign loop_en  = ctl_ff[`SCA_CTL_LOOP];

	// ****************************************************************
	// transmit capture and line drive
	// ****************************************************************
	logic [`SCA_WORD_W-1:0] tx_hold_ff;

	// one word per tick, all bits at once
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_hold_ff <= `SCA_WORD_ZERO;
		end else begin
			tx_hold_ff <= tx_word_i;
		end
	end

	// beat bit 0 leaves first in time
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			serial_tx_o.pos <= `SCA_WORD_ZERO;
			serial_tx_o.neg <= `SCA_WORD_ONES;
		end else if (loop_en) begin
			serial_tx_o.pos <= `SCA_WORD_ONES;
			serial_tx_o.neg <= `SCA_WORD_ZERO;
		end else begin
			serial_tx_o.pos <= tx_hold_ff;
			serial_tx_o.neg <= ~tx_hold_ff;
		end
	end

	// ****************************************************************
	// receive beat history
	// ****************************************************************
	logic [`SCA_WORD_W-1:0] rx_beat_ff;
	logic [`SCA_WORD_W-1:0] rx_prev_ff;
	logic [`SCA_WIN_W-1:0]  rx_win;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_beat_ff <= `SCA_WORD_ZERO;
			rx_prev_ff <= `SCA_WORD_ZERO;
		end else begin
			rx_beat_ff <= loop_en ? tx_hold_ff : serial_rx_i;
			rx_prev_ff <= rx_beat_ff;
		end
	end

	// older beat in the low half, so bit index follows arrival order
	assign rx_win = {rx_beat_ff, rx_prev_ff};

	// ****************************************************************
	// comma search over every boundary offset
	// ****************************************************************
	function automatic logic [`SCA_WORD_W-1:0] word_at(
		input logic [`SCA_WIN_W-1:0] win,
		input logic [`SCA_OFF_W-1:0] off
	);
		word_at = win[off +: `SCA_WORD_W];
	endfunction

	function automatic logic is_comma(input logic [`SCA_WORD_W-1:0] w);
		is_comma = (w[`SCA_COMMA_W-1:0] == `SCA_COMMA_PAT);
	endfunction

	logic [`SCA_OFF_CNT-1:0] hit_vec;

	// covers in-word offsets and commas straddling two beats
	generate
		for (gi = 0; gi < `SCA_OFF_CNT; gi = gi + 1) begin : g_det
			assign hit_vec[gi] = is_comma(word_at(rx_win, (`SCA_OFF_W)'(gi)));
		end
	endgenerate

	logic                  hit;
	logic [`SCA_OFF_W-1:0] hit_off;

	// earliest comma in the window wins
	always_comb begin
		hit     = 1'b0;
		hit_off = `SCA_OFF_RST;
		for (int k = `SCA_OFF_CNT - 1; k >= 0; k--) begin
			if (hit_vec[k]) begin
				hit     = 1'b1;
				hit_off = k[`SCA_OFF_W-1:0];
			end
		end
	end

	// ****************************************************************
	// word boundary
	// ****************************************************************
	logic [`SCA_OFF_W-1:0] off_ff;
	logic [`SCA_OFF_W-1:0] nxt_off;
	logic                  realign;

	assign realign = align_en && hit;
	assign nxt_off = realign ? hit_off : off_ff;

	// reset value is just a starting point, not a known alignment
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			off_ff <= `SCA_OFF_RST;
		end else begin
			off_ff <= nxt_off;
		end
	end

	// ****************************************************************
	// recovered clock phase
	// ****************************************************************
	sca_phase_type phase_ff;
	sca_phase_type nxt_phase;

	// comma word must be launched with the odd clock edge
	always_comb begin
		case (phase_ff)
			SCA_PH_EVEN: nxt_phase = SCA_PH_ODD;
			SCA_PH_ODD:  nxt_phase = realign ? SCA_PH_ODD : SCA_PH_EVEN;
			default:     nxt_phase = SCA_PH_EVEN;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_ff <= SCA_PH_ODD;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			recovered_clk_even_o <= 1'b0;
			recovered_clk_odd_o  <= 1'b1;
		end else begin
			recovered_clk_even_o <= (nxt_phase == SCA_PH_EVEN);
			recovered_clk_odd_o  <= (nxt_phase == SCA_PH_ODD);
		end
	end

	// ****************************************************************
	// receive word and comma flag
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_o.word            <= `SCA_WORD_ZERO;
			rx_o.comma_seen_flag <= 1'b0;
		end else begin
			rx_o.word            <= word_at(rx_win, nxt_off);
			rx_o.comma_seen_flag <= align_en && is_comma(word_at(rx_win, nxt_off));
		end
	end

endmodule

`default_nettype wire

/* verif/sca_port_chk_sva.sv */
// assertion checker for the comma align port
`timescale 1ns/100ps
`default_nettype none
`include "sca_cfg.svh"

module sca_port_chk
	import sca_pkg::*;
(
	input wire logic         core_clk_i,
	input wire logic         resetn_i,
	input wire logic [9:0]   tx_word_i,
	input wire logic         comma_align_enable_i,
	input wire logic         internal_loopback_sel_i,
	input wire sca_line_type serial_tx_o,
	input wire sca_rx_type   rx_o,
	input wire logic         recovered_clk_even_o,
	input wire logic         recovered_clk_odd_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	AST_CLK_PAIR: assert property (recovered_clk_odd_o != recovered_clk_even_o)
		else $error("recovered clocks not complementary");
	AST_TX_ORDER: assert property ((!internal_loopback_sel_i)[*8] |=> serial_tx_o.pos == $past(tx_word_i, 2))
		else $error("transmit beat wrong");
	AST_TX_DIFF: assert property (serial_tx_o.neg == ~serial_tx_o.pos)
		else $error("line halves not complementary");
	AST_LOOP_LINE: assert property (internal_loopback_sel_i[*8] |=> serial_tx_o.pos == 10'h3FF)
		else $error("line not forced in loopback");
	AST_FLAG_OFF: assert property ((!comma_align_enable_i)[*8] |=> !rx_o.comma_seen_flag)
		else $error("flag while alignment off");
	AST_FLAG_PAT: assert property (rx_o.comma_seen_flag |-> rx_o.word[6:0] == `SCA_COMMA_PAT)
		else $error("flag without comma word");
	AST_FLAG_ODD: assert property (rx_o.comma_seen_flag |-> recovered_clk_odd_o)
		else $error("comma word not on odd clock");
	AST_FLAG_ONE: assert property (rx_o.comma_seen_flag |=> !rx_o.comma_seen_flag)
		else $error("flag longer than one word");
endmodule

bind sca_comma_align_port sca_port_chk i_chk (
	.core_clk_i              (core_clk_i),
	.resetn_i                (resetn_i),
	.tx_word_i               (tx_word_i),
	.comma_align_enable_i    (comma_align_enable_i),
	.internal_loopback_sel_i (internal_loopback_sel_i),
	.serial_tx_o             (serial_tx_o),
	.rx_o                    (rx_o),
	.recovered_clk_even_o    (recovered_clk_even_o),
	.recovered_clk_odd_o     (recovered_clk_odd_o)
);

`default_nettype wire

/* verif/sca_pcs_model.sv */
// upstream coding logic model feeding transmit words
`timescale 1ns/100ps
`default_nettype none

module sca_pcs_model (
	input  wire logic       clk_i,
	input  wire logic       comma_req_i,
	output var  logic [9:0] tx_word_o
);
	logic ph_ff;

	initial begin
		ph_ff = 1'b0;
		tx_word_o = 10'h155;
	end

	// one new word every tick, back to back
	always @(negedge clk_i) begin
		ph_ff <= ~ph_ff;
		tx_word_o <= comma_req_i ? 10'h17C : (ph_ff ? 10'h2AA : 10'h155);
	end
endmodule

`default_nettype wire

/* verif/testbench.sv */
// self-checking testbench for the comma align port
`timescale 1ns/100ps
`default_nettype none

module testbench
	import sca_pkg::*;
;
	logic         core_clk;
	logic         resetn;
	logic         en;
	logic         loop;
	logic         req;
	logic [9:0]   tx_word;
	logic [9:0]   serial_rx;
	logic [59:0]  st;
	logic [9:0]   w [16];
	sca_line_type tx_line;
	sca_rx_type   rx;
	int           failures;
	int           checks;

	sca_comma_align_port i_dut (.core_clk_i(core_clk), .resetn_i(resetn), .tx_word_i(tx_word),
		.serial_rx_i(serial_rx), .comma_align_enable_i(en), .internal_loopback_sel_i(loop),
		.serial_tx_o(tx_line), .rx_o(rx), .recovered_clk_even_o(), .recovered_clk_odd_o());
	sca_pcs_model i_pcs (.clk_i(core_clk), .comma_req_i(req), .tx_word_o(tx_word));

	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic give_verdict();
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// drive beats from st, record words, note first flagged word
	task automatic watch(output int k);
		k = -1;
		for (int i = 0; i < 16; i++) begin
			@(negedge core_clk);
			serial_rx <= (i < 6) ? st[10*i +: 10] : 10'h155;
			if (rx.comma_seen_flag === 1'b1 && k < 0)
				k = i;
			w[i] = rx.word;
		end
	endtask

	task automatic t_tx();
		logic [9:0] p1;
		for (int i = 0; i < 12; i++) begin
			@(negedge core_clk);
			if (i > 0) chk(tx_line.pos, p1);
			p1 = tx_word;
		end
	endtask

	// comma at bit offset s, then two data words
	task automatic t_rx(input int s, input logic e);
		int k;
		int n;
		en <= e;
		st = {10'h155, 10'h2AA, 10'h0F0, 10'h17C, 10'h155, 10'h155} << s;
		repeat (8) @(negedge core_clk);
		watch(k);
		if (e) begin
			chk(w[k], 10'h17C);
			chk(w[k+1], 10'h0F0);
			chk(w[k+2], 10'h2AA);
		end else begin
			n = (k >= 0) ? 1 : 0;
			foreach (w[i]) if (w[i] === 10'h17C) n++;
			chk(n[9:0], 10'h000);
		end
	endtask

	task automatic t_loop();
		int k;
		loop <= 1'b1;
		st = {6{10'h155}};
		repeat (8) @(negedge core_clk);
		chk(tx_line.pos, 10'h3FF);
		chk(tx_line.neg, 10'h000);
		req <= 1'b1;
		@(negedge core_clk);
		req <= 1'b0;
		watch(k);
		chk(w[k], 10'h17C);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	initial begin
		resetn = 1'b0;
		en = 1'b0;
		loop = 1'b0;
		req = 1'b0;
		serial_rx = 10'h155;
		failures = 0;
		checks = 0;
		repeat (10) @(negedge core_clk);
		resetn <= 1'b1;
		repeat (10) @(negedge core_clk);
		t_tx();
		t_rx(3, 1'b1);
		t_rx(0, 1'b0);
		t_rx(7, 1'b1);
		t_loop();
		give_verdict();
	end

	initial begin
		#20us;
		failures++;
		give_verdict();
	end
endmodule

`default_nettype wire
